// File: core/bms_defines.svh
// Purpose: constants for the block move sequencer
// Assumes: 16-bit pointers and count, byte-wide memory bus
// Notes: included by the package and the top module
// Functional notes
// - each iteration reads a byte at source pointer, writes it at destination pointer
// - source pointer increments by one after each copied byte
// - destination pointer increments by one after each copied byte, in step
// - count decrements by one per byte; repeat until count is zero
// - zero count at start performs no transfer and finishes at once
// - byte form uses the low 8-bit count; word form uses full 16 bits
// - execution time grows with the count n
`ifndef BMS_DEFINES_SVH
`define BMS_DEFINES_SVH
`define BMS_AW 16
`define BMS_CW 16
`define BMS_BW 8
`define BMS_ONE 16'h0001
`define BMS_ZERO16 16'h0000
`define BMS_ZERO8 8'h00
`define BMS_ZERO4 4'h0
`define BMS_ONE8 8'h01
`endif

// File: core/bms_pkg.sv
// Purpose: types for the block move sequencer
// Assumes: defines header present
// Notes: state encoding is gray along idle-read-write-done
`include "bms_defines.svh"
package bms_pkg;
  typedef enum logic [1:0]
  {
    BMS_IDLE = 2'h0,
    BMS_READ = 2'h1,
    BMS_WRITE = 2'h3,
    BMS_DONE = 2'h2
  } bms_state_t;

  typedef struct packed
  {
    logic [`BMS_AW-1:0] src;
    logic [`BMS_AW-1:0] dst;
    logic [`BMS_CW-1:0] cnt;
  } bms_regs_t;

  typedef struct packed
  {
    logic rd;
    logic wr;
    logic [`BMS_AW-1:0] addr;
    logic [`BMS_BW-1:0] wdata;
  } bms_mem_req_t;
endpackage : bms_pkg

// File: core/bms_step.sv
// Purpose: next pointer and count values for one copied byte
// Assumes: combinational, used by the sequencer
// Notes: byte form keeps the count high byte untouched
`include "bms_defines.svh"
module bms_step
  import bms_pkg::*;
(
  // current values
  input wire bms_regs_t cur,
  input wire logic word_mode,
  // stepped values
  output bms_regs_t nxt
);
  always_comb
  begin
    nxt.src = cur.src + `BMS_ONE;
    nxt.dst = cur.dst + `BMS_ONE;
    if (word_mode)
    begin
      nxt.cnt = cur.cnt - `BMS_ONE;
    end
    else
    begin
      // an 8-bit step, so the borrow never reaches the high byte
      nxt.cnt = {cur.cnt[`BMS_CW-1:`BMS_BW], cur.cnt[`BMS_BW-1:0] - `BMS_ONE8};
    end
  end
endmodule : bms_step

// File: core/bms_seq.sv
// Purpose: sequencer for the block move instruction
// Assumes: memory answers each request with a one-cycle ack, read data valid with ack
// Notes: register file loads counts at start and takes results back at done
`include "bms_defines.svh"
module bms_seq
  import bms_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // instruction start
  input wire logic START,
  input wire logic WORD_MODE,
  input wire logic [`BMS_AW-1:0] SRC_IN,
  input wire logic [`BMS_AW-1:0] DST_IN,
  input wire logic [`BMS_CW-1:0] CNT_IN,
  input wire logic [3:0] CCR_IN,
  // memory bus
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [`BMS_AW-1:0] MEM_ADDR,
  output logic [`BMS_BW-1:0] MEM_WDATA,
  input wire logic [`BMS_BW-1:0] MEM_RDATA,
  input wire logic MEM_ACK,
  // results
  output logic BUSY,
  output logic DONE,
  output logic [`BMS_AW-1:0] SRC_OUT,
  output logic [`BMS_AW-1:0] DST_OUT,
  output logic [`BMS_CW-1:0] CNT_OUT,
  output logic [3:0] CCR_OUT
);
  // ***************************
  // state
  // ***************************
  bms_state_t state;
  // operands of the running instruction
  bms_regs_t regs;
  bms_regs_t next_regs;
  bms_mem_req_t req;
  logic word_mode;
  logic [3:0] ccr;
  logic zero_now;
  logic last_byte;
  logic issue_read;
  logic issue_write;

  // stepped values stand ready before the write ack, so the last byte is known there
  bms_step bms_step_inst
  (
    .cur(regs),
    .word_mode(word_mode),
    .nxt(next_regs)
  );

  // count value that the chosen form looks at
  assign zero_now = WORD_MODE ? (CNT_IN == `BMS_ZERO16)
                              : (CNT_IN[`BMS_BW-1:0] == `BMS_ZERO8);
  assign last_byte = word_mode ? (next_regs.cnt == `BMS_ZERO16)
                               : (next_regs.cnt[`BMS_BW-1:0] == `BMS_ZERO8);

  // ***************************
  // sequence
  // ***************************
  // one byte costs a read and a write, so time grows linearly with n
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state <= BMS_IDLE;
    end
    else
    begin
      case (state)
        BMS_IDLE:
        begin
          if (START)
          begin
            state <= zero_now ? BMS_DONE : BMS_READ;
          end
        end
        BMS_READ:
        begin
          if (MEM_ACK)
          begin
            state <= BMS_WRITE;
          end
        end
        BMS_WRITE:
        begin
          if (MEM_ACK)
          begin
            state <= last_byte ? BMS_DONE : BMS_READ;
          end
        end
        BMS_DONE:
        begin
          state <= BMS_IDLE;
        end
        default:
        begin
          state <= BMS_IDLE;
        end
      endcase
    end
  end

  // ***************************
  // pointers and count
  // ***************************
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      regs <= '0;
    end
    else if (state == BMS_IDLE && START)
    begin
      regs.src <= SRC_IN;
      regs.dst <= DST_IN;
      regs.cnt <= CNT_IN;
    end
    else if (state == BMS_WRITE && MEM_ACK)
    begin
      regs <= next_regs;
    end
  end

  // form and flags are taken once per instruction; flags pass through untouched
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      word_mode <= 1'b0;
      ccr <= `BMS_ZERO4;
    end
    else if (state == BMS_IDLE && START)
    begin
      word_mode <= WORD_MODE;
      ccr <= CCR_IN;
    end
  end

  // ***************************
  // memory requests
  // ***************************
  // requests are registered from the same conditions as the state, so they change on the same edge as it;
  // only one strobe is up at a time, and none in the done cycle
  // a read opens each byte, on start or on the ack of a write that is not the last
  assign issue_read = (state == BMS_IDLE && START && !zero_now)
                      || (state == BMS_WRITE && MEM_ACK && !last_byte);
  // the write of each byte follows the ack of its read
  assign issue_write = (state == BMS_READ) && MEM_ACK;

  // the read byte is kept in the request itself, so no separate data buffer is needed
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      req <= '0;
    end
    else if (issue_read)
    begin
      req.rd <= 1'b1;
      req.wr <= 1'b0;
      req.addr <= (state == BMS_IDLE) ? SRC_IN : next_regs.src;
    end
    else if (issue_write)
    begin
      req.rd <= 1'b0;
      req.wr <= 1'b1;
      req.addr <= regs.dst;
      req.wdata <= MEM_RDATA;
    end
    else
    begin
      // a strobe stands until its ack; the last write ack leaves the bus idle
      req.rd <= (state == BMS_READ) && !MEM_ACK;
      req.wr <= (state == BMS_WRITE) && !MEM_ACK;
    end
  end

  assign MEM_RD = req.rd;
  assign MEM_WR = req.wr;
  assign MEM_ADDR = req.addr;
  assign MEM_WDATA = req.wdata;

  // ***************************
  // status and results
  // ***************************
  // busy drops in the done cycle, so a start may already stand there;
  // done is a one-cycle pulse
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      BUSY <= 1'b0;
      DONE <= 1'b0;
    end
    else
    begin
      BUSY <= (state == BMS_IDLE) ? START : (state != BMS_DONE);
      DONE <= (state == BMS_DONE);
    end
  end

  // results stand from one done until the next
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      SRC_OUT <= `BMS_ZERO16;
      DST_OUT <= `BMS_ZERO16;
      CNT_OUT <= `BMS_ZERO16;
      CCR_OUT <= `BMS_ZERO4;
    end
    else if (state == BMS_DONE)
    begin
      SRC_OUT <= regs.src;
      DST_OUT <= regs.dst;
      CNT_OUT <= regs.cnt;
      CCR_OUT <= ccr;
    end
  end
endmodule : bms_seq

// File: tb/bms_mem.sv
// Purpose: byte memory partner. Assumes: one ack per request. Notes: ack delay is random.
module bms_mem
(
  input wire logic CLK, MEM_RD, MEM_WR,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  output logic [7:0] MEM_RDATA,
  output logic MEM_ACK
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] m [0:65535];
  int seed = 19624;
  initial for (int i = 0; i < 65536; i++) m[i] = 8'(i * 7);
  // data only valid with ack; inverted otherwise so a stale read shows
  assign MEM_RDATA = MEM_ACK ? m[MEM_ADDR] : ~m[MEM_ADDR];
  always @(posedge CLK)
  begin
    MEM_ACK <= (MEM_RD || MEM_WR) && !MEM_ACK && 1'($random(seed));
    if (MEM_WR && MEM_ACK)
      m[MEM_ADDR] <= MEM_WDATA;
  end
endmodule : bms_mem

// File: tb/bms_seq_monitor.sv
// Purpose: bms_seq checker. Assumes: one clock. Notes: bound at foot.
module bms_seq_monitor
(
  input wire logic CLK, RST_N, START, WORD_MODE, MEM_RD, MEM_WR, MEM_ACK, BUSY, DONE,
  input wire logic [15:0] SRC_IN, DST_IN, CNT_IN, MEM_ADDR,
  input wire logic [7:0] MEM_RDATA, MEM_WDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] s0, d0, n0, nw, n;
  logic go;
  assign go = START && !BUSY;
  assign n = WORD_MODE ? CNT_IN : {8'h00, CNT_IN[7:0]};
  // writes acked since the accepted start
  always_ff @(posedge CLK)
  begin
    if (go)
    begin
      s0 <= SRC_IN;
      d0 <= DST_IN;
      n0 <= n;
    end
    nw <= (!RST_N || go) ? 16'h0000 : nw + {15'h0000, MEM_WR && MEM_ACK};
  end
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  AST_ZERO: assert property (go && n == 16'h0000 |=> (!MEM_RD && !MEM_WR) [*2] ##0 DONE)
    else $error("zero");
  AST_FIRST: assert property (go && n != 16'h0000 |=> MEM_RD && MEM_ADDR == $past(SRC_IN))
    else $error("first");
  AST_SRC: assert property (MEM_RD |-> MEM_ADDR == s0 + nw)
    else $error("src");
  AST_DST: assert property (MEM_WR |-> !MEM_RD && MEM_ADDR == d0 + nw)
    else $error("dst");
  AST_COPY: assert property (MEM_RD && MEM_ACK |=> MEM_WR && MEM_WDATA == $past(MEM_RDATA))
    else $error("copy");
  AST_HOLD: assert property (MEM_WR && !MEM_ACK |=> MEM_WR && $stable(MEM_ADDR))
    else $error("hold");
  AST_RHOLD: assert property (MEM_RD && !MEM_ACK |=> MEM_RD && $stable(MEM_ADDR))
    else $error("read hold");
  AST_BUSY: assert property (go |=> BUSY && !DONE)
    else $error("busy");
  AST_LAST: assert property (MEM_WR && MEM_ACK && nw + 16'h0001 == n0
    |=> !MEM_RD && !MEM_WR ##1 DONE)
    else $error("last");
  AST_COUNT: assert property (DONE |-> nw == n0)
    else $error("count");
endmodule : bms_seq_monitor

bind bms_seq bms_seq_monitor bms_seq_monitor_inst (.CLK, .RST_N, .START, .WORD_MODE, .MEM_RD,
  .MEM_WR, .MEM_ACK, .BUSY, .DONE, .SRC_IN, .DST_IN, .CNT_IN, .MEM_ADDR, .MEM_RDATA, .MEM_WDATA);

// File: tb/bms_seq_test.sv
// Purpose: bms_seq bench. Assumes: bms_mem partner. Notes: fixed seed, corners first.
module bms_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RST_N = 1'b0, START = 1'b0, WORD_MODE = 1'b0;
  logic MEM_RD, MEM_WR, MEM_ACK, BUSY, DONE;
  logic [15:0] SRC_IN = 16'h0000, DST_IN = 16'h0000, CNT_IN = 16'h0000;
  logic [15:0] MEM_ADDR, SRC_OUT, DST_OUT, CNT_OUT;
  logic [7:0] MEM_WDATA, MEM_RDATA;
  logic [3:0] CCR_IN = 4'h0, CCR_OUT;
  logic [7:0] r [0:65535];
  int seed = 19624, mismatches = 0, n_tests = 0;
  bms_seq bms_seq_inst (.CLK, .RST_N, .START, .WORD_MODE, .SRC_IN, .DST_IN, .CNT_IN, .CCR_IN,
    .MEM_RD, .MEM_WR, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA, .MEM_ACK,
    .BUSY, .DONE, .SRC_OUT, .DST_OUT, .CNT_OUT, .CCR_OUT);
  bms_mem bms_mem_inst (.CLK, .MEM_RD, .MEM_WR, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA, .MEM_ACK);
  always #5 CLK = ~CLK;

  task chk(input logic ok, input string what);
    n_tests++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk

  // the byte form only ever counts down its low byte
  function automatic logic [15:0] exp_cnt(input logic w, input logic [15:0] c);
    return w ? 16'h0000 : {c[15:8], 8'h00};
  endfunction : exp_cnt

  task stop_test;
    $display("checks %0d bad %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task run(input logic w, input logic [15:0] s, d, c, input logic [3:0] f);
    int n, t;
    n = w ? int'(c) : int'(c[7:0]);
    for (t = 0; t < n; t++)
      r[16'(d + t)] = r[16'(s + t)];
    @(posedge CLK);
    START <= 1'b1;
    WORD_MODE <= w;
    SRC_IN <= s;
    DST_IN <= d;
    CNT_IN <= c;
    CCR_IN <= f;
    t = 0;
    do
    begin
      @(posedge CLK);
      // a start while busy brings another source pointer and must be ignored
      START <= t == 3 && n > 2;
      SRC_IN <= ~s;
      #1 t++;
    end
    while (DONE !== 1'b1 && t < 20000);
    chk({SRC_OUT, DST_OUT} === {16'(s + n), 16'(d + n)}, "ptr");
    chk({CNT_OUT, CCR_OUT} === {exp_cnt(w, c), f}, "cnt");
    for (t = 0; t < n; t++)
      chk(bms_mem_inst.m[16'(d + t)] === r[16'(d + t)], "data");
    $display("run done n=%0d", n);
  endtask : run

  initial
  begin
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    r = bms_mem_inst.m;
    run(1'b0, 16'h1000, 16'h2000, 16'h0300, 4'hA);
    run(1'b1, 16'h1000, 16'h2000, 16'h0000, 4'h5);
    run(1'b1, 16'hFFFE, 16'h0010, 16'h0004, 4'hF);
    run(1'b0, 16'h3000, 16'h3001, 16'hAB05, 4'h3);
    repeat (8)
      run(1'($random(seed)), 16'($random(seed)), 16'($random(seed)),
        16'($random(seed)) & 16'h033F, 4'($random(seed)));
    stop_test;
  end

  initial
  begin
    // at most about 7000 bytes, some ten cycles each with random acks
    #700us;
    mismatches++;
    stop_test;
  end
endmodule : bms_seq_test
